// ---- inc/tpcs_pkg.sv ----
// Constants, register map and carrier types for the shared timer prescaler
// and timer clock source block.
// Assumes a CPU I/O register port on sys_clk and count pins from outside.

`default_nettype none

package tpcs_pkg;

  // ----------------------------------------------------------------
  // Register map (I/O addresses)
  // ----------------------------------------------------------------
  localparam logic [6:0] IO_PRESCALER_RESET = 7'h30;
  localparam logic [6:0] IO_BYTE_COUNT      = 7'h32;
  localparam logic [6:0] IO_BYTE_CONTROL    = 7'h33;
  localparam logic [6:0] IO_IRQ_FLAGS       = 7'h38;
  localparam logic [6:0] IO_IRQ_MASK        = 7'h39;
  localparam logic [6:0] DATA_SPACE_OFFSET  = 7'h20;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         OVF_BIT      = 0;
  localparam int         RESTART_BIT  = 0;
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic [7:0] FLAGS_RESET  = 8'h00;
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic [2:0] SELECT_RESET = 3'h0;
  localparam logic [7:0] COUNT_MAX    = 8'hFF;

  // ----------------------------------------------------------------
  // Prescaler tap masks on the 10-bit counter
  // ----------------------------------------------------------------
  localparam int          PRESCALE_WIDTH = 10;
  localparam logic [9:0]  TAP_8_MASK     = 10'h007;
  localparam logic [9:0]  TAP_64_MASK    = 10'h03F;
  localparam logic [9:0]  TAP_256_MASK   = 10'h0FF;
  localparam logic [9:0]  TAP_1024_MASK  = 10'h3FF;

  // ----------------------------------------------------------------
  // Clock select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_STOP    = 3'h0;
  localparam logic [2:0] SEL_DIRECT  = 3'h1;
  localparam logic [2:0] SEL_DIV8    = 3'h2;
  localparam logic [2:0] SEL_DIV64   = 3'h3;
  localparam logic [2:0] SEL_DIV256  = 3'h4;
  localparam logic [2:0] SEL_DIV1024 = 3'h5;
  localparam logic [2:0] SEL_FALL    = 3'h6;
  localparam logic [2:0] SEL_RISE    = 3'h7;

  // CPU I/O register request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } tpcs_io_req_s;

  // Prescaler tap enables, one cycle wide each
  typedef struct packed {
    logic div8;
    logic div64;
    logic div256;
    logic div1024;
  } tpcs_taps_s;

endpackage

`default_nettype wire

// ---- design/tpcs_top.sv ----
// Shared prescaler, timer clock selection, 8-bit counter with overflow flag
// and mask, and prescaler restart control.
// Assumes a single-cycle CPU I/O register port and asynchronous count pins.

`default_nettype none

module tpcs_top (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  // CPU register port, either I/O or data-space address
  input  wire tpcs_pkg::tpcs_io_req_s io_req,
  output logic [7:0]                 io_rdata,
  // Core status and vector acknowledge
  input  wire logic                  global_irq_enable,
  input  wire logic                  overflow_vector_ack,
  output logic                       overflow_irq_req,
  // External count pins
  input  wire logic                  count_pin_a,
  input  wire logic                  count_pin_b,
  // Second timer clock select and its tick
  input  wire logic [2:0]            word_timer_clock_select,
  output logic                       word_timer_tick
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [6:0] io_addr;
  logic       hit_restart;
  logic       hit_count;
  logic       hit_control;
  logic       hit_flags;
  logic       hit_mask;

  // Data-space addresses fold back onto I/O addresses
  always_comb begin
    io_addr = io_req.addr;
    if (io_req.addr >= tpcs_pkg::DATA_SPACE_OFFSET + tpcs_pkg::IO_PRESCALER_RESET) begin
      io_addr = io_req.addr - tpcs_pkg::DATA_SPACE_OFFSET;
    end
  end

  assign hit_restart = (io_addr == tpcs_pkg::IO_PRESCALER_RESET);
  assign hit_count   = (io_addr == tpcs_pkg::IO_BYTE_COUNT);
  assign hit_control = (io_addr == tpcs_pkg::IO_BYTE_CONTROL);
  assign hit_flags   = (io_addr == tpcs_pkg::IO_IRQ_FLAGS);
  assign hit_mask    = (io_addr == tpcs_pkg::IO_IRQ_MASK);

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  logic [9:0]           prescale_ff;
  tpcs_pkg::tpcs_taps_s taps;
  logic                 restart_req;

  // Restart strobe is the write itself, so the bit never holds a one
  assign restart_req = io_req.wr && hit_restart && io_req.wdata[tpcs_pkg::RESTART_BIT];

  // Free running regardless of clock selects; only reset and a restart touch it
  always_ff @(posedge sys_clk) begin
    if (!resetn || restart_req) begin
      prescale_ff <= '0;
    end else begin
      prescale_ff <= prescale_ff + 10'h001;
    end
  end

  // Taps fire in the cycle the low bits are all ones
  always_comb begin
    taps.div8    = (prescale_ff & tpcs_pkg::TAP_8_MASK)    == tpcs_pkg::TAP_8_MASK;
    taps.div64   = (prescale_ff & tpcs_pkg::TAP_64_MASK)   == tpcs_pkg::TAP_64_MASK;
    taps.div256  = (prescale_ff & tpcs_pkg::TAP_256_MASK)  == tpcs_pkg::TAP_256_MASK;
    taps.div1024 = (prescale_ff & tpcs_pkg::TAP_1024_MASK) == tpcs_pkg::TAP_1024_MASK;
  end

  // ----------------------------------------------------------------
  // Count pin synchronisers and edge detectors
  // ----------------------------------------------------------------
  // The front latch is modelled as a flop; a real transparent latch gains
  // half a cycle, hence the 2.5 to 3.5 cycle spread on hardware.
  logic [1:0] pin_meta_ff;
  logic [1:0] pin_sync_ff;
  logic [1:0] pin_last_ff;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;

  // Pins are sampled whether driven as outputs or not
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pin_meta_ff <= 2'h0;
      pin_sync_ff <= 2'h0;
      pin_last_ff <= 2'h0;
    end else begin
      pin_meta_ff <= {count_pin_b, count_pin_a};
      pin_sync_ff <= pin_meta_ff;
      pin_last_ff <= pin_sync_ff;
    end
  end

  assign pin_rise = pin_sync_ff & ~pin_last_ff;
  assign pin_fall = ~pin_sync_ff & pin_last_ff;

  // ----------------------------------------------------------------
  // Clock select, one mux per timer on the shared taps
  // ----------------------------------------------------------------
  function automatic logic pick_tick(input logic [2:0] sel, input tpcs_pkg::tpcs_taps_s t,
                                     input logic rise, input logic fall);
    logic tick;
    tick = 1'b0;
    case (sel)
      tpcs_pkg::SEL_STOP:    tick = 1'b0;
      tpcs_pkg::SEL_DIRECT:  tick = 1'b1;
      tpcs_pkg::SEL_DIV8:    tick = t.div8;
      tpcs_pkg::SEL_DIV64:   tick = t.div64;
      tpcs_pkg::SEL_DIV256:  tick = t.div256;
      tpcs_pkg::SEL_DIV1024: tick = t.div1024;
      tpcs_pkg::SEL_FALL:    tick = fall;
      tpcs_pkg::SEL_RISE:    tick = rise;
      default:               tick = 1'b0;
    endcase
    return tick;
  endfunction

  logic [2:0] byte_timer_clock_select_ff;
  logic       timer_tick;
  logic       word_tick;

  assign timer_tick = pick_tick(byte_timer_clock_select_ff, taps, pin_rise[0], pin_fall[0]);
  assign word_tick  = pick_tick(word_timer_clock_select, taps, pin_rise[1], pin_fall[1]);

  // Second timer tick is registered to keep outputs on flops
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      word_timer_tick <= 1'b0;
    end else begin
      word_timer_tick <= word_tick;
    end
  end

  // ----------------------------------------------------------------
  // Byte timer control and counter
  // ----------------------------------------------------------------
  logic [7:0] byte_timer_count_ff;
  logic       overflow_evt;

  // Clock select of the 8-bit timer
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      byte_timer_clock_select_ff <= tpcs_pkg::SELECT_RESET;
    end else if (io_req.wr && hit_control) begin
      byte_timer_clock_select_ff <= io_req.wdata[2:0];
    end
  end

  // A CPU write wins over the count and suppresses the overflow
  assign overflow_evt = timer_tick && !(io_req.wr && hit_count) &&
                        (byte_timer_count_ff == tpcs_pkg::COUNT_MAX);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      byte_timer_count_ff <= tpcs_pkg::COUNT_RESET;
    end else if (io_req.wr && hit_count) begin
      byte_timer_count_ff <= io_req.wdata;
    end else if (timer_tick) begin
      byte_timer_count_ff <= byte_timer_count_ff + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Overflow flag and mask
  // ----------------------------------------------------------------
  logic overflow_flag_ff;
  logic overflow_irq_enable_ff;
  logic flag_clear;

  assign flag_clear = overflow_vector_ack ||
                      (io_req.wr && hit_flags && io_req.wdata[tpcs_pkg::OVF_BIT]);

  // Set beats a clear in the same cycle so no overflow is lost
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      overflow_flag_ff <= tpcs_pkg::FLAGS_RESET[tpcs_pkg::OVF_BIT];
    end else if (overflow_evt) begin
      overflow_flag_ff <= 1'b1;
    end else if (flag_clear) begin
      overflow_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      overflow_irq_enable_ff <= tpcs_pkg::MASK_RESET[tpcs_pkg::OVF_BIT];
    end else if (io_req.wr && hit_mask) begin
      overflow_irq_enable_ff <= io_req.wdata[tpcs_pkg::OVF_BIT];
    end
  end

  // Request follows the three conditions one cycle later, unless the flag is being cleared in that cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      overflow_irq_req <= 1'b0;
    end else begin
      overflow_irq_req <= overflow_irq_enable_ff && global_irq_enable && overflow_flag_ff &&
                          !flag_clear;
    end
  end

  // ----------------------------------------------------------------
  // Read data, registered; unmapped addresses read zero
  // ----------------------------------------------------------------
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 8'h00;
    if (hit_count) begin
      nxt_rdata = byte_timer_count_ff;
    end else if (hit_control) begin
      nxt_rdata = {5'h00, byte_timer_clock_select_ff};
    end else if (hit_flags) begin
      nxt_rdata = {7'h00, overflow_flag_ff};
    end else if (hit_mask) begin
      nxt_rdata = {7'h00, overflow_irq_enable_ff};
    end else if (hit_restart) begin
      nxt_rdata = 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      io_rdata <= 8'h00;
    end else if (io_req.rd) begin
      io_rdata <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence wrap_tick;
    timer_tick && byte_timer_count_ff == tpcs_pkg::COUNT_MAX && !(io_req.wr && hit_count);
  endsequence

  chk_irq_gating: assert property (@(posedge sys_clk) disable iff (!resetn)
    overflow_irq_req |-> $past(overflow_irq_enable_ff) && $past(global_irq_enable) && $past(overflow_flag_ff))
    else $error("overflow request without all three enables");

  chk_ovf_set: assert property (@(posedge sys_clk) disable iff (!resetn)
    wrap_tick |=> overflow_flag_ff && byte_timer_count_ff == 8'h00)
    else $error("overflow flag not set on wrap");

  chk_ovf_ack: assert property (@(posedge sys_clk) disable iff (!resetn)
    overflow_vector_ack && !overflow_evt |=> !overflow_flag_ff)
    else $error("vector did not clear flag");

  chk_ovf_w1c: assert property (@(posedge sys_clk) disable iff (!resetn)
    io_req.wr && hit_flags && !io_req.wdata[0] && !overflow_vector_ack |=> overflow_flag_ff == $past(overflow_flag_ff) || overflow_flag_ff)
    else $error("writing zero cleared flag");

  chk_direct_tick: assert property (@(posedge sys_clk) disable iff (!resetn)
    byte_timer_clock_select_ff == tpcs_pkg::SEL_DIRECT && !io_req.wr |=>
    byte_timer_count_ff == $past(byte_timer_count_ff) + 8'h01)
    else $error("direct clock did not count");

  chk_div8_period: assert property (@(posedge sys_clk) disable iff (!resetn || restart_req)
    taps.div8 |=> !taps.div8 [*7] ##1 taps.div8)
    else $error("divide by 8 tap period wrong");

  chk_restart: assert property (@(posedge sys_clk) disable iff (!resetn)
    restart_req |=> prescale_ff == 10'h000)
    else $error("prescaler not restarted");

  chk_rise_delay: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(pin_meta_ff[0]) |=> pin_rise[0])
    else $error("rising edge not detected in time");

  chk_stop: assert property (@(posedge sys_clk) disable iff (!resetn)
    byte_timer_clock_select_ff == tpcs_pkg::SEL_STOP && !io_req.wr |=> $stable(byte_timer_count_ff))
    else $error("stopped timer counted");

endmodule

`default_nettype wire

// ---- verification/tpcs_pin_source.sv ----
// Behavioural source of external count pulses for both count pins.
// Assumes the bench strobes go_a or go_b for one cycle while busy is low.

`default_nettype none

module tpcs_pin_source #(
  parameter int HALF   = 3,
  parameter int PULSES = 5
) (
  // Clock and requests
  input  wire logic sys_clk,
  input  wire logic go_a,
  input  wire logic go_b,
  // Pins and status
  output logic      pin_a,
  output logic      pin_b,
  output logic      busy
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Pulse train
  // ------------------------------------------------------------
  logic sel;

  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
    busy  = 1'b0;
  end

  // Half period of several cycles keeps sampling safe; pins rest low between trains
  always begin
    @(posedge sys_clk);
    if (go_a || go_b) begin
      sel = go_b;
      busy <= 1'b1;
      // Toggles land by non-blocking assignment on the edge, so the design sees them one edge later
      repeat (2 * PULSES) begin
        repeat (HALF) @(posedge sys_clk);
        if (sel) pin_b <= !pin_b;
        else pin_a <= !pin_a;
      end
      busy <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ---- verification/tb_timer_prescaler_clock_select.sv ----
// Self-checking bench for the shared prescaler and timer clock source.
// Assumes the single-cycle I/O register port of tpcs_top and tpcs_pin_source.

`default_nettype none

module tb_timer_prescaler_clock_select;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic                  sys_clk, resetn, gie, vack, irq, wtick;
  logic                  pin_a, pin_b, go_a, go_b, busy;
  logic [7:0]            rdata;
  logic [2:0]            wsel;
  tpcs_pkg::tpcs_io_req_s io_req;
  int                    error_cnt, n_tests, n, k;
  int                    divs [5] = '{1, 8, 64, 256, 1024};

  tpcs_top uut (
    .sys_clk(sys_clk), .resetn(resetn), .io_req(io_req), .io_rdata(rdata),
    .global_irq_enable(gie), .overflow_vector_ack(vack), .overflow_irq_req(irq),
    .count_pin_a(pin_a), .count_pin_b(pin_b),
    .word_timer_clock_select(wsel), .word_timer_tick(wtick));

  tpcs_pin_source src (
    .sys_clk(sys_clk), .go_a(go_a), .go_b(go_b),
    .pin_a(pin_a), .pin_b(pin_b), .busy(busy));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h", $time, m, got);
    end
  endtask

  task automatic chkn(input int got, input int lo, input int hi, input string m);
    n_tests++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("unexpected at %0t: %s count %0d", $time, m, got);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk) io_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge sys_clk) io_req <= '0;
  endtask

  // Read data is registered on the taking edge, so look just after it
  task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string m);
    @(posedge sys_clk) io_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge sys_clk) io_req <= '0;
    #1 chk(rdata, exp, m);
  endtask

  // Cycles until the next word tick; a bound that runs out ends the run
  task automatic wait_tick(input int lim, output int c);
    c = 0;
    do begin
      @(negedge sys_clk);
      c++;
    end while (wtick !== 1'b1 && c < lim);
    if (wtick !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: no tick", $time);
      give_verdict();
    end
  endtask

  // One pulse train on a pin, counting word ticks meanwhile
  task automatic pulse(input logic b, output int c);
    c = 0;
    @(posedge sys_clk) begin go_a <= !b; go_b <= b; end
    @(posedge sys_clk) begin go_a <= 1'b0; go_b <= 1'b0; end
    for (int i = 0; i < 60; i++) begin
      @(negedge sys_clk);
      c += (wtick === 1'b1);
    end
    chk({7'h00, busy}, 8'h00, "source idle");
  endtask

  // ------------------------------------------------------------
  // Clock and main sequence
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    resetn = 1'b0; io_req = '0; gie = 1'b0; vack = 1'b0;
    wsel = 3'h0; go_a = 1'b0; go_b = 1'b0;
    error_cnt = 0; n_tests = 0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    // Register reset values, data-space alias, unmapped place
    rd(7'h39, 8'h00, "mask reset");
    rd(7'h38, 8'h00, "flag reset");
    wr(7'h59, 8'h01);
    rd(7'h39, 8'h01, "mask alias");
    rd(7'h3A, 8'h00, "unmapped");
    $display("test registers done");
    // Tap spacing for every internal select code
    for (k = 1; k <= 5; k++) begin
      wsel <= k[2:0];
      wait_tick(2100, n);
      wait_tick(2100, n);
      chkn(n, divs[k-1], divs[k-1], "tap gap");
    end
    wsel <= 3'h0;
    // A stopped select never ticks, so only let the registered tick drain
    repeat (3) @(negedge sys_clk);
    n = 0;
    for (int i = 0; i < 1100; i++) begin
      @(negedge sys_clk);
      n += (wtick === 1'b1);
    end
    chkn(n, 0, 0, "stopped ticks");
    $display("test taps done");
    // Prescaler restart realigns the divide-by-64 tap
    wsel <= 3'h3;
    wait_tick(200, n);
    repeat (20) @(posedge sys_clk);
    wr(7'h30, 8'h01);
    wait_tick(200, n);
    chkn(n, 60, 68, "restart gap");
    rd(7'h30, 8'h00, "restart reads 0");
    wsel <= 3'h0;
    $display("test restart done");
    // Overflow flag, interrupt request, clearing paths
    wr(7'h33, 8'h01);
    wr(7'h32, 8'hFD);
    gie <= 1'b1;
    n = 0;
    while (irq !== 1'b1 && n < 20) begin @(negedge sys_clk); n++; end
    chk({7'h00, irq}, 8'h01, "irq raised");
    wr(7'h33, 8'h00);
    rd(7'h38, 8'h01, "flag set");
    gie <= 1'b0;
    repeat (3) @(negedge sys_clk);
    chk({7'h00, irq}, 8'h00, "irq gated");
    wr(7'h38, 8'h00);
    rd(7'h38, 8'h01, "write zero");
    wr(7'h58, 8'h01);
    rd(7'h38, 8'h00, "write one");
    wr(7'h33, 8'h01);
    wr(7'h32, 8'hFE);
    wr(7'h33, 8'h00);
    rd(7'h38, 8'h01, "flag again");
    @(posedge sys_clk) vack <= 1'b1;
    @(posedge sys_clk) vack <= 1'b0;
    rd(7'h38, 8'h00, "vector clear");
    $display("test overflow done");
    // External pins on both timers; selects change only while pins rest
    for (k = 6; k <= 7; k++) begin
      wr(7'h32, 8'h00);
      wr(7'h33, {5'h00, k[2:0]});
      pulse(1'b0, n);
      chkn(n, 0, 0, "other timer idle");
      wr(7'h33, 8'h00);
      rd(7'h32, 8'h05, "pin a count");
      wsel <= k[2:0];
      pulse(1'b1, n);
      chkn(n, 5, 5, "pin b ticks");
      wsel <= 3'h0;
    end
    $display("test pins done");
    give_verdict();
  end
endmodule

`default_nettype wire
